// ===== hdl/uar_defines.svh
/*
 contents: constants for the upper address rebuild decoder: shadow register
 indices, reset values, field positions and counts.
 assumes: included by bare name from the package and the decoder top module.
*/
`ifndef UAR_DEFINES_SVH
`define UAR_DEFINES_SVH

// ==========================================================
// shadow register set layout (register indices)
`define UAR_NREGS 32
`define UAR_IDX_PORTE 5'h01
`define UAR_IDX_DDRE 5'h02
`define UAR_IDX_PORTF 5'h03
`define UAR_IDX_DDRF 5'h04
`define UAR_IDX_CSPAR0 5'h05
`define UAR_IDX_CSPAR1 5'h06
`define UAR_IDX_CSBASE0 5'h08
// ==========================================================
// reset values of the shadow set
`define UAR_RST_CSPAR0 16'h3FFF
`define UAR_RST_CSPAR1 16'h03FF
`define UAR_RST_BOOT_BASE 16'h0007
`define UAR_RST_OTHER 16'h0000
// ==========================================================
// fields
`define UAR_BASE_ADDR_LSB 8
`define UAR_NLINES 11
`define UAR_ADDR_LINE0 6
`define UAR_FC_LINE0 3
`define UAR_GRANT_ACK_LINE 2
`define UAR_FC_USER_DATA 3'h1

`endif

// ===== hdl/uar_pkg.sv
/*
 contents: types shared by the upper address rebuild decoder.
 assumes: the defines header is on the include path.
*/
`include "uar_defines.svh"
package uar_pkg;
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      UAR_IDLE,
      UAR_TO_CPU,
      UAR_FROM_CPU_RD,
      UAR_FROM_CPU_WR,
      UAR_CMP
   } uar_seq_t;
   // ==========================================================
   // commands
   typedef enum logic [1:0] {
      UAR_CMD_TO_CPU,
      UAR_CMD_FROM_CPU,
      UAR_CMD_COMPARE,
      UAR_CMD_DEFAULT
   } uar_cmd_t;
endpackage

// ===== hdl/uar_line_decode.sv
/*
 contents: rebuilds one upper address bit from line mode and chip-select
 base of the shadow copy.
 assumes: all inputs synchronous to clk; output registered by caller.
*/
`timescale 1ns/1ns
module uar_line_decode
   import uar_pkg::*;
(
   // line state
   input wire logic line_is_cs,
   input wire logic line_level,
   // shadow base bit for this line's address
   input wire logic base_bit,
   // rebuilt bit
   output logic addr_bit
);
   // ==========================================================
   // select pass-through or rebuild
   always_comb begin
      if (line_is_cs) begin
         // line lost to a chip select: the base word holds the address
         addr_bit = base_bit;
      end else begin
         addr_bit = line_level;
      end
   end
endmodule

// ===== hdl/uar_address_rebuild_decoder.sv
/*
 contents: upper address rebuild decoder with shadow configuration set,
 copy to and from the processor, compare and restore-defaults sequencer.
 assumes: one clock, synchronous high reset; processor register port is a
 simple one-cycle read/write port answered combinationally.
*/
// Function
// - drive rebuilt A23-A19 and FC2-0 out
// - inputs: port C, boot select, size pins
// - cycle-in-progress from strobe or chip selects
// - chip-select lines: rebuild bits from shadow base
// - only shadow set steers decoding
// - shadow drives both mapper and trace view
// - reset and default request restore reset values
// - monitor break from reset copies shadow out
// - copy request reads processor into shadow
// - compare reports differing pairs, ports outputs only
`timescale 1ns/1ns
`include "uar_defines.svh"
module uar_address_rebuild_decoder
   import uar_pkg::*;
#(
   parameter int NREGS = `UAR_NREGS
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // processor bus pins
   input wire logic [10:0] port_c_lines,
   input wire logic boot_chip_select,
   input wire logic [1:0] transfer_size_pins,
   input wire logic address_strobe,
   // command port
   input wire logic cmd_valid,
   input wire uar_cmd_t cmd,
   output logic cmd_ready,
   input wire logic monitor_break_from_reset,
   // shadow write port from the controlling host
   input wire logic shadow_we,
   input wire logic [4:0] shadow_idx,
   input wire logic [15:0] shadow_wdata,
   output logic [15:0] shadow_rdata,
   // processor integration module register port
   output logic cpu_reg_we,
   output logic cpu_reg_re,
   output logic [4:0] cpu_reg_idx,
   output logic [15:0] cpu_reg_wdata,
   input wire logic [15:0] cpu_reg_rdata,
   // compare report
   output logic diff_valid,
   output logic [4:0] diff_idx,
   output logic [15:0] diff_cpu_value,
   output logic [15:0] diff_shadow_value,
   output logic compare_done,
   // rebuilt address to mapper and analyzer
   output logic [23:19] upper_addr,
   output logic [2:0] function_code_lines,
   output logic bus_cycle_active
);
   // ==========================================================
   // storage
   logic [15:0] shadow_r [NREGS]; // shadow configuration set
   uar_seq_t seq_r; // sequencer state
   logic [4:0] ptr_r; // register walker
   logic [15:0] capt_r; // value read from processor
   logic [23:19] addr_nxt;
   logic [4:0] line_cs; // address lines now chip selects

   // reset value of one shadow register
   function automatic logic [15:0] rst_val(input logic [4:0] i);
      case (i)
         `UAR_IDX_CSPAR0: rst_val = `UAR_RST_CSPAR0;
         `UAR_IDX_CSPAR1: rst_val = `UAR_RST_CSPAR1;
         `UAR_IDX_CSBASE0: rst_val = `UAR_RST_BOOT_BASE;
         default: rst_val = `UAR_RST_OTHER;
      endcase
   endfunction

   // compare mask: port data only where direction says output
   function automatic logic [15:0] cmp_mask(input logic [4:0] i);
      if (i == `UAR_IDX_PORTE) begin
         cmp_mask = {8'h00, shadow_r[`UAR_IDX_DDRE][7:0]};
      end else if (i == `UAR_IDX_PORTF) begin
         cmp_mask = {8'h00, shadow_r[`UAR_IDX_DDRF][7:0]};
      end else begin
         cmp_mask = 16'hFFFF;
      end
   endfunction

   // ==========================================================
   // line mode from pin assignment register, shadow only
   // each line owns a two-bit field; non-zero means chip select
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         line_cs[k] = |shadow_r[`UAR_IDX_CSPAR1][2*k +: 2];
      end
   end

   // ==========================================================
   // one rebuild slice per upper address bit
   for (genvar g = 0; g < 5; g++) begin : g_line
      uar_line_decode u_dec (
         .line_is_cs(line_cs[g]),
         .line_level(port_c_lines[`UAR_ADDR_LINE0 + g]),
         .base_bit(shadow_r[`UAR_IDX_CSBASE0 + g][`UAR_BASE_ADDR_LSB + 3 + g]),
         .addr_bit(addr_nxt[19 + g])
      );
   end

   // ==========================================================
   // registered address and function code outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         upper_addr <= 5'h00;
         function_code_lines <= 3'h0;
      end else begin
         upper_addr <= addr_nxt;
         // function code lines lost to chip selects read as user data
         if (|shadow_r[`UAR_IDX_CSPAR0][7:6]) begin
            function_code_lines <= `UAR_FC_USER_DATA;
         end else begin
            function_code_lines <= port_c_lines[`UAR_FC_LINE0 +: 3];
         end
      end
   end

   // ==========================================================
   // bus cycle in progress: strobe, or any enabled chip select low
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_cycle_active <= 1'b0;
      end else if (shadow_r[`UAR_IDX_CSPAR0][0]) begin
         // chip selects qualify the cycle; size pins gate partial moves
         bus_cycle_active <= ~boot_chip_select |
            (|(~port_c_lines & {line_cs, 6'h00})) |
            (~address_strobe & (transfer_size_pins != 2'h3));
      end else begin
         bus_cycle_active <= ~address_strobe;
      end
   end

   // ==========================================================
   // sequencer for copy out, copy in, compare
   assign cmd_ready = (seq_r == UAR_IDLE);
   always_ff @(posedge clk) begin
      if (rst) begin
         seq_r <= UAR_IDLE;
         ptr_r <= 5'h00;
         capt_r <= 16'h0000;
      end else begin
         case (seq_r)
            UAR_IDLE: begin
               ptr_r <= 5'h00;
               // break from reset wins over a host command
               if (monitor_break_from_reset) begin
                  seq_r <= UAR_TO_CPU;
               end else if (cmd_valid) begin
                  case (cmd)
                     UAR_CMD_TO_CPU: seq_r <= UAR_TO_CPU;
                     UAR_CMD_FROM_CPU: seq_r <= UAR_FROM_CPU_RD;
                     UAR_CMD_COMPARE: seq_r <= UAR_CMP;
                     default: seq_r <= UAR_IDLE;
                  endcase
               end
            end
            UAR_TO_CPU, UAR_CMP: begin
               ptr_r <= ptr_r + 5'h01;
               if (ptr_r == 5'(NREGS - 1)) begin
                  seq_r <= UAR_IDLE;
               end
            end
            UAR_FROM_CPU_RD: begin
               capt_r <= cpu_reg_rdata;
               seq_r <= UAR_FROM_CPU_WR;
            end
            UAR_FROM_CPU_WR: begin
               ptr_r <= ptr_r + 5'h01;
               seq_r <= (ptr_r == 5'(NREGS - 1)) ? UAR_IDLE : UAR_FROM_CPU_RD;
            end
            default: seq_r <= UAR_IDLE;
         endcase
      end
   end

   // processor port strobes follow state
   always_comb begin
      cpu_reg_idx = ptr_r;
      cpu_reg_wdata = shadow_r[ptr_r];
      cpu_reg_we = (seq_r == UAR_TO_CPU);
      cpu_reg_re = (seq_r == UAR_FROM_CPU_RD) || (seq_r == UAR_CMP);
   end

   // ==========================================================
   // shadow set storage; sequencer copy wins over host write
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NREGS; i++) begin
            shadow_r[i] <= rst_val(5'(i));
         end
      end else if (cmd_ready && cmd_valid && cmd == UAR_CMD_DEFAULT &&
                   !monitor_break_from_reset) begin
         for (int i = 0; i < NREGS; i++) begin
            shadow_r[i] <= rst_val(5'(i));
         end
      end else if (seq_r == UAR_FROM_CPU_WR) begin
         shadow_r[ptr_r] <= capt_r;
      end else if (shadow_we && cmd_ready) begin
         // host loads only while idle, keeping copies coherent
         shadow_r[shadow_idx] <= shadow_wdata;
      end
   end
   assign shadow_rdata = shadow_r[shadow_idx];

   // ==========================================================
   // compare report, one pulse per differing pair
   always_ff @(posedge clk) begin
      if (rst) begin
         diff_valid <= 1'b0;
         diff_idx <= 5'h00;
         diff_cpu_value <= 16'h0000;
         diff_shadow_value <= 16'h0000;
         compare_done <= 1'b0;
      end else begin
         // masked difference, so port input pins never report
         diff_valid <= (seq_r == UAR_CMP) &&
            (((cpu_reg_rdata ^ shadow_r[ptr_r]) & cmp_mask(ptr_r))
             != 16'h0000);
         diff_idx <= ptr_r;
         diff_cpu_value <= cpu_reg_rdata;
         diff_shadow_value <= shadow_r[ptr_r];
         compare_done <= (seq_r == UAR_CMP) && (ptr_r == 5'(NREGS - 1));
      end
   end
endmodule

// ===== test/uar_checker.sv
/*
 holds: port timing checks for the upper address rebuild decoder.
 assumes: bound to the decoder top, one clock, synchronous high reset.
*/
`timescale 1ns/1ns
module uar_checker
   import uar_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command port
   input wire logic cmd_valid,
   input wire uar_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic monitor_break_from_reset,
   // processor register port
   input wire logic cpu_reg_we,
   input wire logic cpu_reg_re,
   input wire logic [4:0] cpu_reg_idx,
   // compare report
   input wire logic diff_valid,
   input wire logic [4:0] diff_idx,
   input wire logic [15:0] diff_cpu_value,
   input wire logic [15:0] diff_shadow_value,
   input wire logic compare_done
);
   // ==========================================================
   // helpers
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic taken; // command accepted, break does not beat it
   assign taken = cmd_valid && cmd_ready && !monitor_break_from_reset;
   // ==========================================================
   // sequencer walks
   property p_cmp_walk;
      taken && cmd == UAR_CMD_COMPARE |=> cpu_reg_re && cpu_reg_idx == 5'h00
      ##31 cpu_reg_re && cpu_reg_idx == 5'h1F ##1 compare_done;
   endproperty
   a_cmp_walk: assert property (p_cmp_walk) else $error("compare walk");
   property p_to_walk;
      taken && cmd == UAR_CMD_TO_CPU |=> cpu_reg_we && cpu_reg_idx == 5'h00
      ##31 cpu_reg_we && cpu_reg_idx == 5'h1F;
   endproperty
   a_to_walk: assert property (p_to_walk) else $error("copy out walk");
   property p_break;
      monitor_break_from_reset && cmd_ready |=>
      cpu_reg_we && cpu_reg_idx == 5'h00 && !cmd_ready;
   endproperty
   a_break: assert property (p_break) else $error("break copy");
   property p_from_walk;
      taken && cmd == UAR_CMD_FROM_CPU |=> cpu_reg_re && cpu_reg_idx == 5'h00
      ##1 !cpu_reg_re ##1 cpu_reg_re && cpu_reg_idx == 5'h01;
   endproperty
   a_from_walk: assert property (p_from_walk) else $error("copy in walk");
   property p_busy;
      taken && cmd != UAR_CMD_DEFAULT |=> !cmd_ready [*8];
   endproperty
   a_busy: assert property (p_busy) else $error("ready while busy");
   property p_default;
      taken && cmd == UAR_CMD_DEFAULT |=> cmd_ready && !cpu_reg_we;
   endproperty
   a_default: assert property (p_default) else $error("default busy");
   // ==========================================================
   // compare report
   property p_diff_cause;
      diff_valid |-> diff_cpu_value != diff_shadow_value
      && $past(cpu_reg_re) && diff_idx == $past(cpu_reg_idx);
   endproperty
   a_diff_cause: assert property (p_diff_cause) else $error("bad diff");
   property p_done_pulse;
      compare_done |=> !compare_done && !diff_valid;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done");
   property p_excl;
      !(cpu_reg_we && cpu_reg_re);
   endproperty
   a_excl: assert property (p_excl) else $error("read and write");
endmodule
bind uar_address_rebuild_decoder uar_checker u_uar_checker (.clk(clk),
   .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
   .monitor_break_from_reset(monitor_break_from_reset),
   .cpu_reg_we(cpu_reg_we), .cpu_reg_re(cpu_reg_re),
   .cpu_reg_idx(cpu_reg_idx), .diff_valid(diff_valid), .diff_idx(diff_idx),
   .diff_cpu_value(diff_cpu_value), .diff_shadow_value(diff_shadow_value),
   .compare_done(compare_done));

// ===== test/uar_cpu_model.sv
/*
 holds: processor integration module register set seen by the decoder.
 assumes: one-cycle port, read answered in the same cycle.
*/
`timescale 1ns/1ns
module uar_cpu_model (
   // register port
   input wire logic clk,
   input wire logic we,
   input wire logic re,
   input wire logic [4:0] idx,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [15:0] regs [32]; // bench presets these directly
   // write lands at the edge
   always @(posedge clk) begin
      if (we) begin
         regs[idx] <= wdata;
      end
   end
   // idle read shows inverse so a stale value never passes
   assign rdata = re ? regs[idx] : ~regs[idx];
endmodule

// ===== test/testbench.sv
/*
 holds: scenario testbench for the upper address rebuild decoder.
 assumes: partner model and checker compiled before this file.
*/
`timescale 1ns/1ns
module testbench
   import uar_pkg::*;
;
   // ==========================================================
   // signals
   logic clk, rst, bcs_n, as_n, cmd_valid, cmd_ready, mbr, we, re, swe;
   logic [10:0] pc;
   logic [1:0] tsz;
   uar_cmd_t cmd;
   logic [4:0] sidx, cidx, didx, last_idx;
   logic [15:0] swd, srd, cwd, crd, dcv, dsv;
   logic [15:0] last_cpu, last_shadow; // values of the last reported pair
   logic dv, done, bca;
   logic [23:19] ua;
   logic [2:0] fc;
   int num_errors, total_checks, ndiff, ndone;
   uar_address_rebuild_decoder u_uar_address_rebuild_decoder (.clk(clk),
      .rst(rst), .port_c_lines(pc), .boot_chip_select(bcs_n),
      .transfer_size_pins(tsz), .address_strobe(as_n), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .monitor_break_from_reset(mbr),
      .shadow_we(swe), .shadow_idx(sidx), .shadow_wdata(swd),
      .shadow_rdata(srd), .cpu_reg_we(we), .cpu_reg_re(re),
      .cpu_reg_idx(cidx), .cpu_reg_wdata(cwd), .cpu_reg_rdata(crd),
      .diff_valid(dv), .diff_idx(didx), .diff_cpu_value(dcv),
      .diff_shadow_value(dsv), .compare_done(done), .upper_addr(ua),
      .function_code_lines(fc), .bus_cycle_active(bca));
   uar_cpu_model u_uar_cpu_model (.clk(clk), .we(we), .re(re), .idx(cidx),
      .wdata(cwd), .rdata(crd));
   // ==========================================================
   // clock, diff monitor, watchdog
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      if (dv === 1'b1) begin
         ndiff++;
         last_idx = didx;
         last_cpu = dcv;
         last_shadow = dsv;
      end
      if (done === 1'b1) begin
         ndone++;
      end
   end
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   // ==========================================================
   // shared tasks
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input logic [4:0] i, input logic [15:0] d);
      @(negedge clk);
      swe = 1;
      sidx = i;
      swd = d;
      @(negedge clk);
      swe = 0;
   endtask
   task rd(input logic [4:0] i, input logic [15:0] e);
      @(negedge clk);
      sidx = i;
      #1 chk("shadow", e, srd);
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) chk("idle", 16'h0001, 16'h0000);
   endtask
   task do_cmd(input uar_cmd_t c);
      @(negedge clk);
      cmd_valid = 1;
      cmd = c;
      @(negedge clk);
      cmd_valid = 0;
      wait_idle();
   endtask
   // ==========================================================
   // scenarios
   task t_defaults;
      rd(5'h05, 16'h3FFF);
      rd(5'h06, 16'h03FF);
      rd(5'h08, 16'h0007);
      wr(5'h05, 16'h1111);
      do_cmd(UAR_CMD_DEFAULT);
      rd(5'h05, 16'h3FFF);
   endtask
   task t_copy_out;
      wr(5'h0C, 16'h1234);
      @(negedge clk);
      mbr = 1;
      @(negedge clk);
      mbr = 0;
      wait_idle();
      chk("cpu12", 16'h1234, u_uar_cpu_model.regs[12]);
      chk("cpu6", 16'h03FF, u_uar_cpu_model.regs[6]);
      wr(5'h0C, 16'h4321);
      do_cmd(UAR_CMD_TO_CPU);
      chk("cpu12", 16'h4321, u_uar_cpu_model.regs[12]);
   endtask
   task t_copy_in_compare;
      for (int i = 0; i < 32; i++) u_uar_cpu_model.regs[i] = 16'hA500 + i;
      // after the copy in both sets hold the same values, until regs 1 and 9 change below
      do_cmd(UAR_CMD_FROM_CPU);
      rd(5'h03, 16'hA503);
      rd(5'h14, 16'hA514);
      // port E bit 0 is an input pin, so its flip stays unreported
      u_uar_cpu_model.regs[9] = 16'hA508;
      u_uar_cpu_model.regs[1] = 16'hA500;
      ndiff = 0;
      ndone = 0;
      do_cmd(UAR_CMD_COMPARE);
      repeat (2) @(negedge clk);
      chk("ndiff", 16'h0001, 16'(ndiff));
      chk("diff_idx", 16'h0009, 16'(last_idx));
      chk("diff_cpu", 16'hA508, last_cpu);
      chk("diff_shadow", 16'hA509, last_shadow);
      chk("done", 16'h0001, 16'(ndone));
   endtask
   task t_address;
      wr(5'h06, 16'h0000);
      wr(5'h05, 16'h0000);
      pc = {5'h15, 3'h5, 3'h0};
      as_n = 0;
      repeat (2) @(negedge clk);
      chk("addr", 16'h0015, 16'(ua));
      chk("fc", 16'h0005, 16'(fc));
      chk("cycle", 16'h0001, 16'(bca));
      as_n = 1;
      repeat (2) @(negedge clk);
      chk("cycle", 16'h0000, 16'(bca));
      // lines as chip selects: bits come from the shadow bases
      wr(5'h06, 16'h03FF);
      wr(5'h05, 16'h00C0);
      // line k takes its bit from base bit 11 + k of its own base word
      for (int k = 0; k < 5; k++) begin
         wr(5'(8 + k), (k % 2) ? 16'(16'h0800 << k) : 16'h0000);
      end
      repeat (2) @(negedge clk);
      chk("addr", 16'h000A, 16'(ua));
      chk("fc", 16'h0001, 16'(fc));
      // chip selects qualify the cycle: boot select or a line low
      wr(5'h05, 16'h00C1);
      pc = {5'h1F, 3'h5, 3'h0};
      repeat (2) @(negedge clk);
      chk("cycle", 16'h0000, 16'(bca));
      bcs_n = 0;
      repeat (2) @(negedge clk);
      chk("cycle", 16'h0001, 16'(bca));
      bcs_n = 1;
      pc[6] = 0;
      repeat (2) @(negedge clk);
      chk("cycle", 16'h0001, 16'(bca));
   endtask
   task finish_test;
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {rst, bcs_n, tsz, as_n, cmd_valid, mbr, swe} = 8'hFF;
      {cmd_valid, mbr, swe} = 3'h0;
      cmd = UAR_CMD_DEFAULT;
      pc = 11'h000;
      sidx = 5'h00;
      swd = 16'h0000;
      repeat (8) @(negedge clk);
      rst = 0;
      t_defaults();
      t_copy_out();
      t_copy_in_compare();
      t_address();
      finish_test();
   end
endmodule
